// ---- rtl/bcr_pkg.sv ----
package bcr_pkg;
   // ----------------------------------------
   // divider and reset timing
   // ----------------------------------------
   localparam int unsigned BCR_DIV_RATIO = 4;
   localparam int unsigned BCR_FAULT_HOLD_BUS_CYC = 4;
   localparam int unsigned BCR_RISE_LIMIT_BUS_CYC = 2;
   localparam logic [1:0] BCR_PH_RST = 2'h0;
   localparam logic [1:0] BCR_PH_HIGH_FIRST = 2'h2;
   localparam logic [7:0] BCR_CNT_RST = 8'h00;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic stop;
      logic single_chip;
      logic out_disable;
   } bcr_ctrl_t;

   typedef struct packed {
      logic o;
      logic oe;
   } bcr_pin_drv_t;

   typedef enum logic [1:0] {
      BCR_RUN,
      BCR_DRIVE,
      BCR_WATCH
   } bcr_state_t;
endpackage

// ---- rtl/bcr_sync.sv ----
`timescale 1ns/1ps
module bcr_sync
   import bcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= 1'b1;
         q_o <= 1'b1;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// ---- rtl/bcr_clock_reset.sv ----
`timescale 1ns/1ps
module bcr_clock_reset
   import bcr_pkg::*;
#(
   parameter bit ALWAYS_ON = 1'b0,
   parameter int unsigned HOLD_BUS_CYC = BCR_FAULT_HOLD_BUS_CYC
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire bcr_ctrl_t ctrl_i,
   input wire logic watchdog_fault_i,
   input wire logic clkmon_fault_i,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_o,
   output logic chip_reset_n_o,
   output logic internal_reset_o,
   output logic class_valid_o,
   output logic bus_clk_o,
   output logic bus_clk_pin_o,
   output logic process_phase_o,
   output logic access_phase_o
);
   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   // hold count must fit the eight bit counter below its saturation value
   if (HOLD_BUS_CYC < 1 || HOLD_BUS_CYC > 60) begin : g_bad_hold
      $error("HOLD_BUS_CYC out of range");
   end
   // two phase bits only serve a ratio of four
   if (BCR_DIV_RATIO != 4) begin : g_bad_ratio
      $error("divide ratio must be four");
   end
   // internal-rise window must end before the rise count saturates
   if (BCR_RISE_LIMIT_BUS_CYC * BCR_DIV_RATIO > 254) begin : g_bad_rise
      $error("rise window too long");
   end

   localparam logic [7:0] HOLD_CNT = 8'((HOLD_BUS_CYC * BCR_DIV_RATIO) - 1);
   localparam logic [7:0] RISE_CNT = 8'(BCR_RISE_LIMIT_BUS_CYC * BCR_DIV_RATIO);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // bus clock level that belongs to a phase count
   function automatic logic phase_is_high(input logic [1:0] ph);
      return ph >= BCR_PH_HIGH_FIRST;
   endfunction

   // saturating step so a pin stuck low never wraps the count
   function automatic logic [7:0] count_step(input logic [7:0] c);
      return (c == 8'hff) ? c : c + 8'h01;
   endfunction

   // ----------------------------------------
   // pin input synchroniser
   // ----------------------------------------
   logic pin_sync;

   bcr_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(reset_pin_i),
      .q_o(pin_sync)
   );

   // ----------------------------------------
   // divide-by-four phase counter
   // ----------------------------------------
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic pin_low;
   wire logic halted = ctrl_i.stop;

   // frozen in stop so e stays put rather than glitching
   assign next_phase = halted ? phase : phase + 2'h1;

   // ----------------------------------------
   // reset pin driver and classification
   // ----------------------------------------
   bcr_state_t state;
   bcr_state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic next_internal;
   logic next_valid;
   wire logic fault = watchdog_fault_i | clkmon_fault_i;

   assign pin_low = ~pin_sync;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_internal = internal_reset_o;
      next_valid = class_valid_o;
      unique case (state)
         BCR_RUN: begin
            if (fault) begin
               next_state = BCR_DRIVE;
               next_cnt = BCR_CNT_RST;
               next_valid = 1'b0;
            end else if (pin_low) begin
               next_state = BCR_WATCH;
               next_cnt = BCR_CNT_RST;
               next_valid = 1'b0;
            end
         end
         BCR_DRIVE: begin
            next_cnt = count_step(cnt);
            if (cnt == HOLD_CNT) begin
               next_state = BCR_WATCH;
               next_cnt = BCR_CNT_RST;
            end
         end
         BCR_WATCH: begin
            // sync delay counted in: rise seen under two bus clocks is internal
            if (!pin_low) begin
               next_state = BCR_RUN;
               next_internal = (cnt < RISE_CNT);
               next_valid = 1'b1;
            end else begin
               next_cnt = count_step(cnt);
            end
         end
         default: begin
            next_state = BCR_RUN;
         end
      endcase
   end

   // ----------------------------------------
   // output decode
   // ----------------------------------------
   logic chip_rst_n;
   logic next_e;
   logic pin_gate_open;
   logic next_e_pin;
   logic next_process;
   logic next_access;
   logic next_chip_rst_n;
   logic next_pin_oe;

   assign next_e = phase_is_high(next_phase);
   // pin gating only honoured in single-chip, and never on the fixed variant
   assign pin_gate_open = ALWAYS_ON | ~(ctrl_i.single_chip & ctrl_i.out_disable);
   assign next_e_pin = next_e & pin_gate_open;
   // phase flags drop in stop: nothing is processed or accessed while frozen
   assign next_process = ~next_e & ~halted;
   assign next_access = next_e & ~halted;
   // chip stays in reset for the whole drive and watch stretch
   assign next_chip_rst_n = (next_state == BCR_RUN);
   assign next_pin_oe = (next_state == BCR_DRIVE);

   // ----------------------------------------
   // divider register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase <= BCR_PH_RST;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------
   // reset sequencer registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= BCR_RUN;
         cnt <= BCR_CNT_RST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ----------------------------------------
   // classification registers
   // ----------------------------------------
   // valid drops at each new reset so stale class is never read
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         internal_reset_o <= 1'b0;
         class_valid_o <= 1'b0;
      end else begin
         internal_reset_o <= next_internal;
         class_valid_o <= next_valid;
      end
   end

   // ----------------------------------------
   // reset pin and chip reset registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         chip_rst_n <= 1'b0;
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= 1'b0;
      end else begin
         chip_rst_n <= next_chip_rst_n;
         reset_pin_o <= 1'b0; // open drain only ever pulls low
         reset_pin_oe_o <= next_pin_oe;
      end
   end

   // ----------------------------------------
   // bus clock registers
   // ----------------------------------------
   // all four registered from one decode so they switch on the same edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus_clk_o <= 1'b0;
         bus_clk_pin_o <= 1'b0;
         process_phase_o <= 1'b0;
         access_phase_o <= 1'b0;
      end else begin
         bus_clk_o <= next_e;
         bus_clk_pin_o <= next_e_pin;
         process_phase_o <= next_process;
         access_phase_o <= next_access;
      end
   end

   assign chip_reset_n_o = chip_rst_n;
endmodule

// ---- bench/bcr_reset_board.sv ----
`timescale 1ns/1ps
module bcr_reset_board (
   input wire logic clk_i,
   input wire logic oe_i,
   input wire logic push_i,
   input wire logic [3:0] lag_i,
   output logic pin_o
);
   logic [3:0] left = 4'h0;
   // slow board: pull-up needs lag cycles to lift the pin
   always @(posedge clk_i) begin
      left <= (oe_i || push_i) ? lag_i : left - 4'(left != 4'h0);
   end
   assign pin_o = !(oe_i || push_i || left != 4'h0);
endmodule

// ---- bench/bcr_clock_reset_props.sv ----
`timescale 1ns/1ps
module bcr_clock_reset_chk
   import bcr_pkg::*;
#(
   parameter bit ALWAYS_ON = 1'b0,
   parameter int unsigned HOLD_BUS_CYC = BCR_FAULT_HOLD_BUS_CYC
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire bcr_ctrl_t ctrl_i,
   input wire logic watchdog_fault_i,
   input wire logic clkmon_fault_i,
   input wire logic reset_pin_i,
   input wire logic reset_pin_oe_o,
   input wire logic chip_reset_n_o,
   input wire logic bus_clk_o,
   input wire logic bus_clk_pin_o,
   input wire logic process_phase_o,
   input wire logic access_phase_o
);
   logic [7:0] held;
   logic [2:0] age;
   // age keeps divider checks off the edges right after reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         held <= 8'h00;
         age <= 3'h0;
      end else begin
         held <= reset_pin_oe_o ? held + 8'h01 : 8'h00;
         age <= (age == 3'h7) ? age : age + 3'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_fault_drives_pin: assert property (
      (watchdog_fault_i || clkmon_fault_i) && chip_reset_n_o && !reset_pin_oe_o
      |=> reset_pin_oe_o) else $error("fault did not drive reset pin");
   chk_hold_length: assert property (
      $fell(reset_pin_oe_o) |-> held == 8'(HOLD_BUS_CYC * BCR_DIV_RATIO))
      else $error("reset pin hold length wrong");
   chk_e_period: assert property (
      age > 3'h4 && !$past(ctrl_i.stop) && !$past(ctrl_i.stop, 2)
      |-> bus_clk_o != $past(bus_clk_o, 2)) else $error("bus clock not divide by four");
   chk_stop_halts: assert property (
      age > 3'h2 && $past(ctrl_i.stop) && $past(ctrl_i.stop, 2)
      |-> $stable(bus_clk_o) && !access_phase_o) else $error("clock ran in stop");
   chk_process_low: assert property (
      process_phase_o |-> !bus_clk_o && !access_phase_o) else $error("process phase wrong");
   chk_access_high: assert property (
      access_phase_o |-> bus_clk_o) else $error("access phase while clock low");
   chk_pin_gated: assert property (
      !ALWAYS_ON && age > 3'h0 && $past(ctrl_i.single_chip && ctrl_i.out_disable)
      |-> !bus_clk_pin_o) else $error("clock pin not gated");
   chk_drive_resets: assert property (
      reset_pin_oe_o |-> !chip_reset_n_o) else $error("chip ran while pin driven");
   chk_pin_resets: assert property (
      !reset_pin_i [*4] |-> !chip_reset_n_o) else $error("chip ran while pin low");
endmodule
bind bcr_clock_reset bcr_clock_reset_chk #(.ALWAYS_ON(ALWAYS_ON),
   .HOLD_BUS_CYC(HOLD_BUS_CYC)) u_chk (.*);

// ---- bench/tb_bcr_clock_reset.sv ----
`timescale 1ns/1ps
module tb_bcr_clock_reset;
   import bcr_pkg::*;
   logic clk_i = 0, rst_n_i = 0, watchdog_fault_i = 0, clkmon_fault_i = 0, push = 0;
   logic reset_pin_i, reset_pin_o, reset_pin_oe_o, chip_reset_n_o, internal_reset_o;
   logic class_valid_o, bus_clk_o, bus_clk_pin_o, process_phase_o, access_phase_o;
   logic on_pin;
   logic [3:0] lag = 4'h0;
   bcr_ctrl_t ctrl_i = '0;
   int fails = 0, samples_checked = 0, seed = 32'h0000_8146, ne, np, nf;
   logic exp_q[$];
   always #5 clk_i = ~clk_i;
   bcr_clock_reset #(.HOLD_BUS_CYC(2)) u_dut (.*);
   // fixed-on variant: only its clock pin is watched
   bcr_clock_reset #(.ALWAYS_ON(1'b1), .HOLD_BUS_CYC(2)) u_dut_on (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .ctrl_i(ctrl_i), .watchdog_fault_i(watchdog_fault_i),
      .clkmon_fault_i(clkmon_fault_i), .reset_pin_i(reset_pin_i), .reset_pin_o(),
      .reset_pin_oe_o(), .chip_reset_n_o(), .internal_reset_o(), .class_valid_o(),
      .bus_clk_o(), .bus_clk_pin_o(on_pin), .process_phase_o(), .access_phase_o());
   bcr_reset_board u_board (.clk_i(clk_i), .oe_i(reset_pin_oe_o), .push_i(push),
      .lag_i(lag), .pin_o(reset_pin_i));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // each new classification pairs with the oldest note
   always @(posedge class_valid_o) begin
      #1;
      check("internal_reset_o", {7'h00, internal_reset_o}, {7'h00, exp_q.pop_front()});
   end
   task automatic count_rises();
      logic pe, pq, po;
      ne = 0;
      np = 0;
      nf = 0;
      repeat (4) @(negedge clk_i);
      pe = bus_clk_o;
      pq = bus_clk_pin_o;
      po = on_pin;
      repeat (40) begin
         @(negedge clk_i);
         ne += (bus_clk_o && !pe);
         np += (bus_clk_pin_o && !pq);
         nf += (on_pin && !po);
         pe = bus_clk_o;
         pq = bus_clk_pin_o;
         po = on_pin;
      end
   endtask
   task automatic wait_class();
      int n;
      n = 0;
      repeat (3) @(negedge clk_i);
      while (class_valid_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      if (class_valid_o !== 1'b1) begin
         fails++;
         finish_test();
      end
      repeat (2) @(negedge clk_i);
   endtask
   initial begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1;
      for (int i = 0; i < 5; i++) begin
         ctrl_i = bcr_ctrl_t'(3'(i));
         count_rises();
         check("bus_clk_o rises", 8'(ne), (i == 4) ? 8'h00 : 8'h0a);
         check("pin rises", 8'(np), (i == 3 || i == 4) ? 8'h00 : 8'h0a);
         check("fixed pin rises", 8'(nf), (i == 4) ? 8'h00 : 8'h0a);
      end
      check("phases in stop", {process_phase_o, access_phase_o}, 8'h00);
      ctrl_i = '0;
      // even passes rise fast enough to count as internal
      for (int i = 0; i < 6; i++) begin
         exp_q.push_back(!i[0]);
         lag = {i[0], i[0], 2'($random(seed))};
         {clkmon_fault_i, watchdog_fault_i} = i[1] ? 2'h2 : 2'h1;
         @(negedge clk_i);
         {clkmon_fault_i, watchdog_fault_i} = 2'h0;
         check("reset_pin_oe_o", {7'h00, reset_pin_oe_o}, 8'h01);
         check("reset_pin_o", {7'h00, reset_pin_o}, 8'h00);
         wait_class();
      end
      lag = 4'h0;
      for (int i = 0; i < 3; i++) begin
         exp_q.push_back(1'b0);
         push = 1;
         repeat (12 + ($unsigned($random(seed)) % 8)) @(negedge clk_i);
         check("chip_reset_n_o", {7'h00, chip_reset_n_o}, 8'h00);
         push = 0;
         wait_class();
         check("chip_reset_n_o", {7'h00, chip_reset_n_o}, 8'h01);
      end
      finish_test();
   end
endmodule
